// *** src/ssf_serial_status.sv ***
// Purpose: status flags, receiver and transmitter of an asynchronous serial port
// Assumes: core_clk_i at 10 MHz, sample tick every SAMPLE_DIV clocks (16 per bit)
// Notes: flags clear only by read-status-then-data-access (tx_complete also by enable rise or break); hardware set beats clear
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - tx_buffer_empty sets at reset and when buffer moves into the shifter
// - tx_buffer_empty clears on data write after status read showing it set
// - tx_complete sets at reset and when buffer empty and nothing shifting
// - tx_complete clears after status read by data write, enable rise, break
// - rx_buffer_full sets when received character moves into data register
// - rx_buffer_full clears by status read showing it, then data read
// - idle flag sets after line high one character time, 10 or 11 bits
// - idle counting starts after start bit, or after stop bit when selected
// - idle flag clears by status read showing it, then data read
// - idle flag rearms only after a new character sets rx_buffer_full
// - overrun sets when new character finds data unread; new character dropped
// - overrun clears by status read showing it, then data read
// - seven start samples, three per bit; any disagreement sets noise flag
// - noise flag clears by status read then data read
// - framing error sets with rx_buffer_full when stop bit samples low
// - framing error clears by status read showing it, then data read
// - parity error sets with rx_buffer_full on parity mismatch when enabled
// - parity error clears by status read then data read
// - status register is read-only; writes ignored
// - odd parity when type bit is one, count includes parity bit
// - lin break detect blocks framing error and rx_buffer_full setting
module ssf_serial_status #(
   parameter int unsigned SAMPLE_DIV = ssf_pkg::SAMPLE_DIV_DEF
) (
   input wire logic core_clk_i,                       // bus clock
   input wire logic rst_n_i,                          // async reset, active low
   input wire logic [ssf_pkg::ADDR_W-1:0] addr_i,     // register address
   input wire logic [ssf_pkg::DATA_W-1:0] wr_data_i,  // write data
   input wire logic wr_i,                             // write strobe
   input wire logic rd_i,                             // read strobe
   output logic [ssf_pkg::DATA_W-1:0] rd_data_o,      // read data, cycle after strobe
   input wire logic rxd_i,                            // receive line pin
   output logic txd_o,                                // transmit line
   output logic txd_oe_o                              // transmit pin driven
);

   // majority of three samples
   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // true when the three samples do not all agree
   function automatic logic split3(input logic [2:0] v);
      split3 = (v != 3'h0) && (v != 3'h7);
   endfunction

   // register port decode
   wire logic rd_status = rd_i && (addr_i == ssf_pkg::ADDR_STATUS);
   wire logic rd_data = rd_i && (addr_i == ssf_pkg::ADDR_DATA);
   wire logic wr_data = wr_i && (addr_i == ssf_pkg::ADDR_DATA);
   wire logic wr_cr1 = wr_i && (addr_i == ssf_pkg::ADDR_CTRL_ONE);
   wire logic wr_cr2 = wr_i && (addr_i == ssf_pkg::ADDR_CTRL_TWO);
   wire logic wr_cr3 = wr_i && (addr_i == ssf_pkg::ADDR_CTRL_THREE);

   // ---------------- configuration and read port ----------------
   ssf_pkg::ssf_cfg_s cfg, next_cfg;
   logic [7:0] rd_data_q, next_rd_data;
   logic [7:0] data_reg, next_data_reg;
   ssf_pkg::ssf_flags_s flags, next_flags;

   // control writes; status writes fall through untouched
   always_comb begin
      next_cfg = cfg;
      if (wr_cr1) begin
         next_cfg.char_length_select = wr_data_i[ssf_pkg::CR1_CHAR_LEN_BIT];
         next_cfg.idle_count_start = wr_data_i[ssf_pkg::CR1_IDLE_START_BIT];
         next_cfg.parity_enable = wr_data_i[ssf_pkg::CR1_PAR_EN_BIT];
         next_cfg.parity_odd = wr_data_i[ssf_pkg::CR1_PAR_ODD_BIT];
      end
      if (wr_cr2) begin
         next_cfg.tx_enable = wr_data_i[ssf_pkg::CR2_TX_EN_BIT];
         next_cfg.send_break = wr_data_i[ssf_pkg::CR2_SBK_BIT];
      end
      if (wr_cr3) begin
         next_cfg.lin_break_detect_en = wr_data_i[ssf_pkg::CR3_LIN_BREAK_DETECT_EN_BIT];
      end
      next_rd_data = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            ssf_pkg::ADDR_STATUS: next_rd_data = flags;
            ssf_pkg::ADDR_DATA: next_rd_data = data_reg;
            ssf_pkg::ADDR_CTRL_ONE: begin
               next_rd_data[ssf_pkg::CR1_CHAR_LEN_BIT] = cfg.char_length_select;
               next_rd_data[ssf_pkg::CR1_IDLE_START_BIT] = cfg.idle_count_start;
               next_rd_data[ssf_pkg::CR1_PAR_EN_BIT] = cfg.parity_enable;
               next_rd_data[ssf_pkg::CR1_PAR_ODD_BIT] = cfg.parity_odd;
            end
            ssf_pkg::ADDR_CTRL_TWO: begin
               next_rd_data[ssf_pkg::CR2_TX_EN_BIT] = cfg.tx_enable;
               next_rd_data[ssf_pkg::CR2_SBK_BIT] = cfg.send_break;
            end
            ssf_pkg::ADDR_CTRL_THREE: begin
               next_rd_data[ssf_pkg::CR3_LIN_BREAK_DETECT_EN_BIT] = cfg.lin_break_detect_en;
            end
            default: next_rd_data = 8'h00; // unmapped reads as zero
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg <= '0;
         rd_data_q <= ssf_pkg::RST_CTRL;
      end else begin
         cfg <= next_cfg;
         rd_data_q <= next_rd_data;
      end
   end
   assign rd_data_o = rd_data_q;

   // ---------------- sample tick divider ----------------
   logic [15:0] sdiv, next_sdiv;
   wire logic tick = (sdiv == 16'(SAMPLE_DIV - 1));

   // one-cycle enable, sixteen per bit time
   always_comb begin
      next_sdiv = tick ? 16'h0000 : sdiv + 16'h0001;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdiv <= 16'h0000;
      end else begin
         sdiv <= next_sdiv;
      end
   end

   // ---------------- receiver ----------------
   logic rx_meta, rx_sync;
   ssf_pkg::ssf_rx_state_e rx_st, next_rx_st;
   logic [3:0] rx_sub, next_rx_sub;
   logic [3:0] rx_bit, next_rx_bit;
   logic [8:0] rx_shift, next_rx_shift;
   logic [2:0] rx_votes, next_rx_votes;
   logic [2:0] rx_ones, next_rx_ones;
   logic rx_noise, next_rx_noise;
   logic [7:0] idle_ticks, next_idle_ticks;
   logic idle_armed, next_idle_armed;
   logic rx_done, rx_stop_ok, rx_noisy;
   logic [7:0] rx_char;
   logic rx_par_bad;
   logic idle_en, idle_hit;

   wire logic [3:0] data_bits = cfg.char_length_select ? 4'h9 : 4'h8;
   wire logic [7:0] idle_limit = cfg.char_length_select ?
      ssf_pkg::IDLE_TICKS_LONG : ssf_pkg::IDLE_TICKS_SHORT;
   wire logic [2:0] stop_votes = {rx_votes[1:0], rx_sync};

   // receive frame walker, idle counter; first sync stage is read only by the second
   always_comb begin
      next_rx_st = rx_st;
      next_rx_sub = rx_sub;
      next_rx_bit = rx_bit;
      next_rx_shift = rx_shift;
      next_rx_votes = rx_votes;
      next_rx_ones = rx_ones;
      next_rx_noise = rx_noise;
      rx_done = 1'b0;
      rx_stop_ok = maj3(stop_votes);
      rx_noisy = rx_noise | split3(stop_votes);
      rx_char = cfg.char_length_select ? rx_shift[7:0] : rx_shift[8:1];
      // count includes the parity bit itself
      rx_par_bad = (cfg.char_length_select ? ^rx_shift : ^rx_shift[8:1]) != cfg.parity_odd;
      if (tick) begin
         next_rx_sub = rx_sub + 4'h1;
         unique case (rx_st)
            ssf_pkg::RX_IDLE: begin
               next_rx_sub = 4'h1;
               next_rx_ones = 3'h0;
               if (!rx_sync) begin
                  next_rx_st = ssf_pkg::RX_START;
               end
            end
            ssf_pkg::RX_START: begin
               // seven samples across the start bit
               if (rx_sub >= ssf_pkg::START_FIRST && rx_sub <= ssf_pkg::START_LAST &&
                   rx_sync) begin
                  next_rx_ones = rx_ones + 3'h1;
               end
               if (rx_sub == ssf_pkg::SUB_LAST) begin
                  // a mostly-high start bit is a glitch, not a frame
                  next_rx_st = (rx_ones >= 3'h4) ? ssf_pkg::RX_IDLE : ssf_pkg::RX_DATA;
                  next_rx_noise = (rx_ones != 3'h0);
                  next_rx_bit = 4'h0;
               end
            end
            ssf_pkg::RX_DATA: begin
               if (rx_sub >= ssf_pkg::VOTE_FIRST && rx_sub <= ssf_pkg::VOTE_LAST) begin
                  next_rx_votes = {rx_votes[1:0], rx_sync};
               end
               if (rx_sub == ssf_pkg::SUB_LAST) begin
                  next_rx_shift = {maj3(rx_votes), rx_shift[8:1]};
                  next_rx_noise = rx_noise | split3(rx_votes);
                  next_rx_bit = rx_bit + 4'h1;
                  if (rx_bit == data_bits - 4'h1) begin
                     next_rx_st = ssf_pkg::RX_STOP;
                  end
               end
            end
            ssf_pkg::RX_STOP: begin
               if (rx_sub >= ssf_pkg::VOTE_FIRST && rx_sub < ssf_pkg::VOTE_LAST) begin
                  next_rx_votes = {rx_votes[1:0], rx_sync};
               end
               // finish after the third stop sample so a next start is not missed
               if (rx_sub == ssf_pkg::VOTE_LAST) begin
                  rx_done = 1'b1;
                  next_rx_st = ssf_pkg::RX_IDLE;
               end
            end
         endcase
      end

      // idle bit-time counter, in sample ticks
      idle_en = rx_sync && ((rx_st == ssf_pkg::RX_IDLE) ||
         (!cfg.idle_count_start &&
         (rx_st == ssf_pkg::RX_DATA || rx_st == ssf_pkg::RX_STOP)));
      idle_hit = 1'b0;
      next_idle_ticks = idle_ticks;
      if (tick) begin
         if (!idle_en) begin
            next_idle_ticks = 8'h00;
         end else if (idle_ticks != idle_limit) begin
            next_idle_ticks = idle_ticks + 8'h01;
            idle_hit = (idle_ticks == idle_limit - 8'h01);
         end
      end
      // saturating count means only one set per idle stretch
      next_idle_armed = idle_armed;
      if (idle_hit) begin
         next_idle_armed = 1'b0;
      end
      if (!flags.rx_buffer_full && next_flags.rx_buffer_full) begin
         next_idle_armed = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_st <= ssf_pkg::RX_IDLE;
         rx_sub <= 4'h0;
         rx_bit <= 4'h0;
         rx_shift <= 9'h000;
         rx_votes <= 3'h7;
         rx_ones <= 3'h0;
         rx_noise <= 1'b0;
         idle_ticks <= 8'h00;
         idle_armed <= 1'b0;
      end else begin
         rx_meta <= rxd_i;
         rx_sync <= rx_meta;
         rx_st <= next_rx_st;
         rx_sub <= next_rx_sub;
         rx_bit <= next_rx_bit;
         rx_shift <= next_rx_shift;
         rx_votes <= next_rx_votes;
         rx_ones <= next_rx_ones;
         rx_noise <= next_rx_noise;
         idle_ticks <= next_idle_ticks;
         idle_armed <= next_idle_armed;
      end
   end

   // ---------------- transmitter ----------------
   logic [7:0] tx_buf, next_tx_buf;
   logic buf_full, next_buf_full;
   logic tx_active, next_tx_active;
   logic [10:0] tx_frame, next_tx_frame;
   logic [3:0] tx_left, next_tx_left;
   logic [3:0] tx_sub, next_tx_sub;
   logic pre_q, next_pre_q;
   logic brk_q, next_brk_q;
   logic txd, next_txd;
   logic txd_oe, next_txd_oe;
   logic tx_loaded;
   logic [7:0] tx_char;
   logic tx_ninth;

   wire logic [3:0] frame_bits = cfg.char_length_select ?
      ssf_pkg::CHAR_BITS_LONG : ssf_pkg::CHAR_BITS_SHORT;
   wire logic tx_en_rise = wr_cr2 && wr_data_i[ssf_pkg::CR2_TX_EN_BIT] && !cfg.tx_enable;
   wire logic sbk_set = wr_cr2 && wr_data_i[ssf_pkg::CR2_SBK_BIT];

   // buffer, queued preamble and breaks, shifter
   always_comb begin
      next_tx_buf = tx_buf;
      next_buf_full = buf_full;
      next_tx_active = tx_active;
      next_tx_frame = tx_frame;
      next_tx_left = tx_left;
      next_tx_sub = tick ? tx_sub + 4'h1 : tx_sub;
      next_pre_q = pre_q | tx_en_rise;
      next_brk_q = brk_q | sbk_set;
      tx_loaded = 1'b0;
      // msb of the character becomes parity when enabled
      tx_char = tx_buf;
      tx_ninth = 1'b1;
      if (cfg.parity_enable) begin
         if (cfg.char_length_select) begin
            tx_ninth = (^tx_buf) ^ cfg.parity_odd;
         end else begin
            tx_char[7] = (^tx_buf[6:0]) ^ cfg.parity_odd;
         end
      end
      if (wr_data) begin
         next_tx_buf = wr_data_i;
         next_buf_full = 1'b1;
      end
      if (tx_active) begin
         if (tick && tx_sub == ssf_pkg::SUB_LAST) begin
            next_tx_frame = {1'b1, tx_frame[10:1]};
            next_tx_left = tx_left - 4'h1;
            if (tx_left == 4'h1) begin
               next_tx_active = 1'b0;
            end
         end
      end else if (cfg.tx_enable) begin
         next_tx_sub = 4'h0;
         next_tx_left = frame_bits;
         // breaks repeat for as long as send_break stays set
         if (brk_q || cfg.send_break) begin
            next_tx_frame = 11'h000;
            next_tx_active = 1'b1;
            next_brk_q = sbk_set;
         end else if (pre_q) begin
            next_tx_frame = 11'h7FF;
            next_tx_active = 1'b1;
            next_pre_q = tx_en_rise;
         end else if (buf_full) begin
            next_tx_frame = cfg.char_length_select ? {1'b1, tx_ninth, tx_char, 1'b0} :
               {2'b11, tx_char, 1'b0};
            next_tx_active = 1'b1;
            next_buf_full = wr_data;
            tx_loaded = 1'b1;
         end
      end
      next_txd = next_tx_active ? next_tx_frame[0] : 1'b1;
      next_txd_oe = next_cfg.tx_enable || next_tx_active;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_buf <= ssf_pkg::RST_DATA;
         buf_full <= 1'b0;
         tx_active <= 1'b0;
         tx_frame <= 11'h7FF;
         tx_left <= 4'h0;
         tx_sub <= 4'h0;
         pre_q <= 1'b0;
         brk_q <= 1'b0;
         txd <= 1'b1;
         txd_oe <= 1'b0;
      end else begin
         tx_buf <= next_tx_buf;
         buf_full <= next_buf_full;
         tx_active <= next_tx_active;
         tx_frame <= next_tx_frame;
         tx_left <= next_tx_left;
         tx_sub <= next_tx_sub;
         pre_q <= next_pre_q;
         brk_q <= next_brk_q;
         txd <= next_txd;
         txd_oe <= next_txd_oe;
      end
   end
   assign txd_o = txd;
   assign txd_oe_o = txd_oe;

   // ---------------- status flags ----------------
   ssf_pkg::ssf_flags_s seen, next_seen;
   ssf_pkg::ssf_flags_s fset, fclr;
   logic rx_take;

   // clears need a prior status read; a same-cycle set always wins
   always_comb begin
      fset = '0;
      fclr = '0;
      next_seen = seen;
      next_data_reg = data_reg;
      rx_take = 1'b0;
      if (rd_status) begin
         next_seen = flags; // remembers which flags software saw at one
      end
      if (rd_data) begin
         fclr.rx_buffer_full = seen.rx_buffer_full;
         fclr.idle_line = seen.idle_line;
         fclr.overrun_flag = seen.overrun_flag;
         fclr.noise_flag = seen.noise_flag;
         fclr.framing_error = seen.framing_error;
         fclr.parity_error = seen.parity_error;
         next_seen.rx_buffer_full = 1'b0;
         next_seen.idle_line = 1'b0;
         next_seen.overrun_flag = 1'b0;
         next_seen.noise_flag = 1'b0;
         next_seen.framing_error = 1'b0;
         next_seen.parity_error = 1'b0;
      end
      if (wr_data) begin
         fclr.tx_buffer_empty = seen.tx_buffer_empty;
         next_seen.tx_buffer_empty = 1'b0;
      end
      if (wr_data || tx_en_rise || sbk_set) begin
         fclr.tx_complete = seen.tx_complete;
         next_seen.tx_complete = 1'b0;
      end
      fset.tx_buffer_empty = tx_loaded;
      // buffer empty and nothing left to shift or queued
      // next-state terms keep a queuing write from re-setting the flag it clears
      fset.tx_complete = flags.tx_buffer_empty && !tx_active && !tx_loaded &&
         !next_tx_active && !next_pre_q && !next_brk_q && !next_buf_full &&
         !next_cfg.send_break;
      fset.idle_line = idle_hit && idle_armed;
      if (rx_done) begin
         if (flags.rx_buffer_full && !fclr.rx_buffer_full) begin
            fset.overrun_flag = 1'b1; // character and its errors dropped
         end else if (!cfg.lin_break_detect_en) begin
            rx_take = 1'b1;
         end
      end
      if (rx_take) begin
         next_data_reg = rx_char;
         fset.rx_buffer_full = 1'b1;
         fset.noise_flag = rx_noisy;
         fset.framing_error = !rx_stop_ok;
         fset.parity_error = cfg.parity_enable && rx_par_bad;
      end
      // status register writes never reach the flags
      next_flags = (flags & ~fclr) | fset;
      if (rx_take) begin
         // the taken character replaces the previous error picture
         next_flags.noise_flag = rx_noisy;
         next_flags.framing_error = !rx_stop_ok;
         next_flags.parity_error = cfg.parity_enable && rx_par_bad;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags <= ssf_pkg::RST_STATUS;
         seen <= '0;
         data_reg <= ssf_pkg::RST_DATA;
      end else begin
         flags <= next_flags;
         seen <= next_seen;
         data_reg <= next_data_reg;
      end
   end

endmodule

`default_nettype wire

// *** src/ssf_pkg.sv ***
// Purpose: shared constants and types for the serial status flag block
// Assumes: 8-bit register port, 16x receive oversampling
// Notes: register offsets and control bit positions are fixed here only
package ssf_pkg;

   // register port geometry
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_DATA = 3'h1;
   localparam logic [2:0] ADDR_CTRL_ONE = 3'h2;
   localparam logic [2:0] ADDR_CTRL_TWO = 3'h3;
   localparam logic [2:0] ADDR_CTRL_THREE = 3'h4;

   // control_reg_one fields
   localparam int unsigned CR1_CHAR_LEN_BIT = 4;
   localparam int unsigned CR1_IDLE_START_BIT = 2;
   localparam int unsigned CR1_PAR_EN_BIT = 1;
   localparam int unsigned CR1_PAR_ODD_BIT = 0;
   // control_reg_two fields
   localparam int unsigned CR2_TX_EN_BIT = 3;
   localparam int unsigned CR2_SBK_BIT = 0;
   // control_reg_three fields
   localparam int unsigned CR3_LIN_BREAK_DETECT_EN_BIT = 1;

   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'hC0;

   // sampling and frame timing, in 16x sample ticks and bit times
   localparam int unsigned OVERSAMPLE = 16;
   localparam logic [3:0] SUB_LAST = 4'hF;
   localparam logic [3:0] START_FIRST = 4'h3;
   localparam logic [3:0] START_LAST = 4'h9;
   localparam logic [3:0] VOTE_FIRST = 4'h7;
   localparam logic [3:0] VOTE_LAST = 4'h9;
   localparam logic [3:0] CHAR_BITS_SHORT = 4'hA;
   localparam logic [3:0] CHAR_BITS_LONG = 4'hB;
   localparam logic [7:0] IDLE_TICKS_SHORT = 8'hA0;
   localparam logic [7:0] IDLE_TICKS_LONG = 8'hB0;
   localparam int unsigned SAMPLE_DIV_DEF = 4;

   // the eight status flags, msb first
   typedef struct packed {
      logic tx_buffer_empty;
      logic tx_complete;
      logic rx_buffer_full;
      logic idle_line;
      logic overrun_flag;
      logic noise_flag;
      logic framing_error;
      logic parity_error;
   } ssf_flags_s;

   // software configuration seen by the datapath
   typedef struct packed {
      logic char_length_select;
      logic idle_count_start;
      logic parity_enable;
      logic parity_odd;
      logic tx_enable;
      logic send_break;
      logic lin_break_detect_en;
   } ssf_cfg_s;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ssf_rx_state_e;

endpackage

// *** sim/ssf_serial_status_checker.sv ***
// Purpose: port checks for the serial status block
// Assumes: status answers one cycle after its read strobe
// Notes: flag relations are seen only through status reads
`timescale 1ns/1ps
`default_nettype none
module ssf_serial_status_checker (
   input wire logic core_clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic [ssf_pkg::ADDR_W-1:0] addr_i, // address
   input wire logic rd_i, // read strobe
   input wire logic [ssf_pkg::DATA_W-1:0] rd_data_o, // read data
   input wire logic txd_o, // tx line
   input wire logic txd_oe_o // tx driven
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic st_q;
   // marks the cycle that carries a status answer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) st_q <= 1'b0;
      else st_q <= rd_i && addr_i == ssf_pkg::ADDR_STATUS;
   end
   property p_rd_quiet; !$past(rd_i) |-> rd_data_o == 8'h00; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");
   property p_tc_tx_buffer_empty; st_q && rd_data_o[6] |-> rd_data_o[7]; endproperty
   a_tc_tx_buffer_empty: assert property (p_tc_tx_buffer_empty) else $error("complete without empty");
   property p_tc_line; st_q && rd_data_o[6] |-> txd_o; endproperty
   a_tc_line: assert property (p_tc_line) else $error("complete while line low");
   property p_low_driven; !txd_o |-> txd_oe_o; endproperty
   a_low_driven: assert property (p_low_driven) else $error("line low undriven");
   property p_fe_full; st_q && rd_data_o[1] |-> rd_data_o[5]; endproperty
   a_fe_full: assert property (p_fe_full) else $error("framing without full");
   property p_nf_full; st_q && rd_data_o[2] |-> rd_data_o[5]; endproperty
   a_nf_full: assert property (p_nf_full) else $error("noise without full");
   property p_pf_full; st_q && rd_data_o[0] |-> rd_data_o[5]; endproperty
   a_pf_full: assert property (p_pf_full) else $error("parity without full");
   // a clear that never lands shows in the status read after the data read
   property p_full_clr; st_q && rd_data_o[5] && rd_i && addr_i == ssf_pkg::ADDR_DATA
      ##1 rd_i && addr_i == ssf_pkg::ADDR_STATUS |=> !rd_data_o[5]; endproperty
   a_full_clr: assert property (p_full_clr) else $error("full not cleared");
endmodule
bind ssf_serial_status ssf_serial_status_checker u_ssf_serial_status_checker (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o));
`default_nettype wire

// *** sim/ssf_remote_node.sv ***
// Purpose: remote serial node driving the receive line
// Assumes: block built with SAMPLE_DIV of 1, so 16 clocks a bit
// Notes: one sample may be flipped to provoke the noise flag
`timescale 1ns/1ps
`default_nettype none
module ssf_remote_node #(
   parameter int TICKS = 16
) (
   input wire logic clk_i, // bus clock
   output logic rxd_o // receive line, idle high
);
   initial rxd_o = 1'b1;
   // tick 8 is the middle vote once the two-flop sync delay is counted
   task automatic send(input logic [7:0] v, input logic stop, input int gl);
      logic [9:0] f;
      f = {stop, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         for (int t = 0; t < TICKS; t++) begin
            @(posedge clk_i);
            rxd_o <= (i == gl && t == 8) ? !f[i] : f[i];
         end
      end
      @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: register-level test of the serial status flags
// Assumes: SAMPLE_DIV of 1, so one bit is 16 clocks
// Notes: flags are checked only through status and data reads
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [9:0] TX_FRAME = 10'h2AA; // stop, 8'h55, start
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wr_data_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rd_data_o;
   logic rxd_i;
   logic txd_o;
   logic txd_oe_o;
   logic [7:0] d;
   int err_count = 0;
   int n_compared = 0;
   initial forever #50 core_clk_i = ~core_clk_i;
   ssf_serial_status #(.SAMPLE_DIV(1)) u_ssf_serial_status (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o));
   ssf_remote_node u_ssf_remote_node (.clk_i(core_clk_i), .rxd_o(rxd_i));
   task automatic test_done;
      if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // bus tasks enter 1 ns after an edge and set both strobes once each
   task automatic nap(input int n);
      rd_i <= 1'b0;
      wr_i <= 1'b0;
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      addr_i <= a;
      wr_data_i <= v;
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic rd(input logic [2:0] a);
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      addr_i <= a;
      @(posedge core_clk_i);
      #1;
      d = rd_data_o;
   endtask
   task automatic st(input logic [7:0] e);
      rd(ssf_pkg::ADDR_STATUS);
      chk("status", d, e);
   endtask
   task automatic rx(input logic [7:0] v, input logic stop, input int gl, input int w);
      nap(1);
      u_ssf_remote_node.send(v, stop, gl);
      nap(w);
   endtask
   // one character, then status, data and the status after the clear
   task automatic frame(input logic [7:0] v, input logic stop, input int gl, input int w,
      input logic [7:0] e);
      rx(v, stop, gl, w);
      st(e);
      rd(ssf_pkg::ADDR_DATA);
      chk("data", d, v);
      st(8'hC0);
   endtask
   initial begin
      #4000000;
      err_count++;
      test_done;
   end
   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      nap(1);
      st(8'hC0);
      wr(ssf_pkg::ADDR_STATUS, 8'hFF);
      st(8'hC0);
      frame(8'h5A, 1'b1, -1, 400, 8'hF0);
      nap(400);
      st(8'hC0);
      rx(8'h11, 1'b1, -1, 1);
      rx(8'h22, 1'b1, -1, 400);
      st(8'hF8);
      rd(ssf_pkg::ADDR_DATA);
      chk("data", d, 8'h11);
      st(8'hC0);
      frame(8'hA5, 1'b0, -1, 400, 8'hF2);
      wr(ssf_pkg::ADDR_CTRL_ONE, 8'h03);
      frame(8'h03, 1'b1, -1, 400, 8'hF1);
      frame(8'h07, 1'b1, -1, 400, 8'hF0);
      wr(ssf_pkg::ADDR_CTRL_ONE, 8'h00);
      frame(8'h00, 1'b1, 3, 400, 8'hF4);
      frame(8'hFF, 1'b1, -1, 60, 8'hF0);
      wr(ssf_pkg::ADDR_CTRL_THREE, 8'h02);
      rx(8'h00, 1'b0, -1, 400);
      st(8'hC0);
      wr(ssf_pkg::ADDR_CTRL_THREE, 8'h00);
      wr(ssf_pkg::ADDR_CTRL_ONE, 8'h04);
      rx(8'hFF, 1'b1, -1, 60);
      st(8'hE0);
      nap(200);
      st(8'hF0);
      rd(ssf_pkg::ADDR_DATA);
      st(8'hC0);
      wr(ssf_pkg::ADDR_CTRL_TWO, 8'h08);
      st(8'h80);
      nap(400);
      st(8'hC0);
      wr(ssf_pkg::ADDR_DATA, 8'h55);
      nap(3);
      st(8'h80);
      nap(4);
      for (int i = 0; i < 10; i++) begin
         chk("txd", {7'h00, txd_o}, {7'h00, TX_FRAME[i]});
         nap(16);
      end
      nap(20);
      st(8'hC0);
      wr(ssf_pkg::ADDR_CTRL_TWO, 8'h09);
      nap(20);
      chk("break", {7'h00, txd_o}, 8'h00);
      st(8'h80);
      wr(ssf_pkg::ADDR_CTRL_TWO, 8'h08);
      nap(400);
      st(8'hC0);
      test_done;
   end
endmodule
`default_nettype wire
